// *** rtl/ahbg_host_glue.v ***
// Host glue: bus decode to converter select and strobes, plus a 16-result collector
// Function
// - Converter mappable in memory or I/O space
// - I/O decode uses low or high address byte
// - I/O space allows narrower port decoder
// - Host strobes, gated by select, drive converter controls when not collecting
// - Port write starts, port read returns result
// - Decode address into active-low converter select
// - Up to eight devices: address bit selects
// - Output bit drives select for controller host
// - Dummy accesses generate read and write strobes
// - Collect sixteen results into consecutive storage
// - Initial selected read clears pending interrupt
// - Select, write, await interrupt, read, deselect
// - Combine generic strobes with request qualifiers
// - Selected I/O cycles stretched by eleven wait cycles (AHBG_STROBE_CYC plus one)
`timescale 1ns/1ps
`include "ahbg_map.vh"
module ahbg_host_glue (
    input  wire        clk,
    input  wire        reset_n,
    input  wire [15:0] cpuAddr,
    input  wire        cpuRead_n,
    input  wire        cpuWrite_n,
    input  wire        memory_request_n,
    input  wire        io_request_n,
    input  wire [1:0]  decodeMode,
    input  wire        useHighByte,
    input  wire        collectStart,
    input  wire        conv_intr_n,
    input  wire [7:0]  convData_i,
    output wire        conv_cs_n,
    output wire        conv_rd_n,
    output wire        conv_wr_n,
    output wire        mem_read_strobe,
    output wire        mem_write_strobe,
    output wire        cpuWait,
    output wire        collectBusy,
    output wire        collectDone,
    output wire [7:0]  resultData,
    output wire [3:0]  resultIndex,
    output wire        resultValid,
    output wire [7:0]  lastResult
);
    ////////////////////////////////////////////////////////////////////////////
    // Bus decode
    localparam S_IDLE  = 6'b00_0001;
    localparam S_CLEAR = 6'b00_0010;
    localparam S_WRITE = 6'b00_0100;
    localparam S_WAIT  = 6'b00_1000;
    localparam S_READ  = 6'b01_0000;
    localparam S_DONE  = 6'b10_0000;

    function [7:0] ioByte;
        input [15:0] a;
        input        hi;
        begin
            ioByte = hi ? a[15:8] : a[7:0];
        end
    endfunction

    // Count one cycle off a strobe or wait counter
    function [3:0] cntDown;
        input [3:0] c;
        begin
            cntDown = c - 4'h1;
        end
    endfunction

    wire       ioRead      = ~cpuRead_n & ~io_request_n;
    wire       ioWrite     = ~cpuWrite_n & ~io_request_n;
    wire       memRead     = ~cpuRead_n & ~memory_request_n;
    wire       memWrite    = ~cpuWrite_n & ~memory_request_n;
    wire [7:0] portNum     = ioByte(cpuAddr, useHighByte);
    wire       ioHit       = (decodeMode == `AHBG_DECODE_IO) &&
                             (portNum == `AHBG_IO_PORT);
    wire       bitHit      = (decodeMode == `AHBG_DECODE_BIT) &&
                             ~cpuAddr[`AHBG_IO_BIT_SEL];
    wire       memHit      = (decodeMode == `AHBG_DECODE_MEM) &&
                             (cpuAddr == `AHBG_MEM_BASE);
    wire       ioCycle     = ioRead | ioWrite;
    wire       busSel      = ((ioHit | bitHit) & ioCycle) |
                             (memHit & (memRead | memWrite));

    ////////////////////////////////////////////////////////////////////////////
    // Wait-state stretch of I/O strobes
    reg  [3:0] waitCnt_reg;
    reg  [3:0] waitCnt_next;
    reg        ioCycleD_reg;
    always @* begin
        waitCnt_next = waitCnt_reg;
        if (ioCycle & ~ioCycleD_reg)
            waitCnt_next = `AHBG_STROBE_CYC;
        else if (waitCnt_reg != 4'h0)
            waitCnt_next = cntDown(waitCnt_reg);
    end
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            waitCnt_reg  <= 4'h0;
            ioCycleD_reg <= 1'b0;
        end else begin
            waitCnt_reg  <= waitCnt_next;
            ioCycleD_reg <= ioCycle;
        end
    end
    assign cpuWait = ioCycle & busSel & ((~ioCycleD_reg) | (waitCnt_reg != 4'h0));

    ////////////////////////////////////////////////////////////////////////////
    // Collector sequencer
    reg [5:0] state_reg;
    reg [5:0] state_next;
    reg [4:0] count_reg;
    reg [4:0] count_next;
    reg [3:0] strobe_reg;
    reg [3:0] strobe_next;
    reg [7:0] result_reg;
    reg [7:0] result_next;
    reg       valid_reg;
    reg       valid_next;
    reg [3:0] index_reg;
    reg [3:0] index_next;
    reg [7:0] store_reg [0:15];

    always @* begin
        state_next  = state_reg;
        count_next  = count_reg;
        strobe_next = strobe_reg;
        result_next = result_reg;
        valid_next  = 1'b0;
        index_next  = index_reg;
        case (state_reg)
            S_IDLE: begin
                if (collectStart) begin
                    state_next  = S_CLEAR;
                    strobe_next = `AHBG_STROBE_CYC;
                    count_next  = `AHBG_CONV_COUNT;
                    index_next  = 4'h0;
                end
            end
            S_CLEAR: begin
                if (strobe_reg == 4'h1) begin
                    state_next  = S_WRITE;
                    strobe_next = `AHBG_STROBE_CYC;
                end else
                    strobe_next = cntDown(strobe_reg);
            end
            S_WRITE: begin
                if (strobe_reg == 4'h1)
                    state_next = S_WAIT;
                else
                    strobe_next = cntDown(strobe_reg);
            end
            S_WAIT: begin
                if (!conv_intr_n) begin
                    state_next  = S_READ;
                    strobe_next = `AHBG_STROBE_CYC;
                end
            end
            S_READ: begin
                if (strobe_reg == 4'h1) begin
                    result_next = convData_i;
                    valid_next  = 1'b1;
                    count_next  = count_reg - 5'h01;
                    if (count_reg == 5'h01)
                        state_next = S_DONE;
                    else begin
                        state_next  = S_WRITE;
                        strobe_next = `AHBG_STROBE_CYC;
                    end
                end else
                    strobe_next = cntDown(strobe_reg);
            end
            S_DONE: begin
                if (!collectStart)
                    state_next = S_IDLE;
            end
            default: state_next = S_IDLE;
        endcase
    end

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg  <= S_IDLE;
            count_reg  <= 5'h00;
            strobe_reg <= 4'h0;
            result_reg <= 8'h00;
            valid_reg  <= 1'b0;
            index_reg  <= 4'h0;
        end else begin
            state_reg  <= state_next;
            count_reg  <= count_next;
            strobe_reg <= strobe_next;
            result_reg <= result_next;
            valid_reg  <= valid_next;
            index_reg  <= valid_reg ? index_reg + 4'h1 : index_next;
        end
    end

    always @(posedge clk) begin
        if (valid_next)
            store_reg[index_reg] <= convData_i;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin drive
    wire seqActive = ~state_reg[0] & ~state_reg[5];
    wire seqSel    = state_reg[1] | state_reg[2] | state_reg[3] | state_reg[4];
    wire seqRead   = state_reg[1] | state_reg[4];
    wire seqWrite  = state_reg[2];

    assign conv_cs_n        = ~(seqActive ? seqSel : busSel);
    assign conv_rd_n        = ~(seqActive ? seqRead : (busSel & (ioRead | memRead)));
    assign conv_wr_n        = ~(seqActive ? seqWrite : (busSel & (ioWrite | memWrite)));
    assign mem_read_strobe  = memRead;
    assign mem_write_strobe = memWrite;
    assign collectBusy      = seqActive;
    assign collectDone      = state_reg[5];
    assign resultData       = result_reg;
    assign resultValid      = valid_reg;
    assign resultIndex      = index_reg;
    assign lastResult       = store_reg[4'hF];
endmodule // ahbg_host_glue

// *** rtl/ahbg_map.vh ***
// Address map, pin constants and timing counts for the converter host glue
`ifndef AHBG_MAP_VH
`define AHBG_MAP_VH
`define AHBG_IO_PORT        8'hE0
`define AHBG_MEM_BASE       16'h4000
`define AHBG_CONV_COUNT     5'h10
`define AHBG_STORE_BASE     5'h00
`define AHBG_DECODE_IO      2'h0
`define AHBG_DECODE_BIT     2'h1
`define AHBG_DECODE_MEM     2'h2
`define AHBG_IO_BIT_SEL     3'h0
`define AHBG_STROBE_NS      40
`define AHBG_STROBE_CYC     4'hA
`endif

// *** tb/adc_host_bus_glue_test.sv ***
// Self-checking bench for the converter host glue
`timescale 1ns/1ps
`include "ahbg_map.vh"
module adc_host_bus_glue_test;
    logic        clk = 0, reset_n = 0, rd_n = 1, wr_n = 1, mrq_n = 1, io_request_n_n = 1;
    logic        useHi = 0, start = 0, csN, crdN, cwrN, intrN, memRd, memWr;
    logic        waitO, busy, done, valid;
    logic [15:0] addr = 16'h0000;
    logic [1:0]  mode = 2'h0;
    logic [7:0]  cData, rData, last;
    logic [3:0]  rIdx;
    int          fail_count = 0, comparisons = 0;
    always #2 clk = ~clk;
    ahbg_host_glue i_dut (.clk(clk), .reset_n(reset_n), .cpuAddr(addr), .cpuRead_n(rd_n),
        .cpuWrite_n(wr_n), .memory_request_n(mrq_n), .io_request_n(io_request_n_n),
        .decodeMode(mode), .useHighByte(useHi), .collectStart(start), .conv_intr_n(intrN),
        .convData_i(cData), .conv_cs_n(csN), .conv_rd_n(crdN), .conv_wr_n(cwrN),
        .mem_read_strobe(memRd), .mem_write_strobe(memWr), .cpuWait(waitO),
        .collectBusy(busy), .collectDone(done), .resultData(rData),
        .resultIndex(rIdx), .resultValid(valid), .lastResult(last));
    ahbg_conv_model i_conv (.clk(clk), .cs_n(csN), .rd_n(crdN), .wr_n(cwrN),
        .intr_n(intrN), .data(cData));
    task automatic end_sim;
        if (fail_count == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic step;
        @(posedge clk);
        #1;
    endtask
    // Bus cycle held until idle is called
    task automatic cyc(input logic [15:0] a, input logic io, input logic rd);
        step;
        {addr, io_request_n_n, mrq_n, rd_n, wr_n} = {a, !io, io, !rd, rd};
        #1;
    endtask
    task automatic idle;
        step;
        {io_request_n_n, mrq_n, rd_n, wr_n} = 4'hF;
    endtask
    task automatic t_collect;
        int k, n;
        start = 1;
        for (k = 0; k < 17; k++) begin
            n = 0;
            while (((k < 16) ? valid : done) !== 1'b1 && n < 400) begin
                step;
                n++;
            end
            if (n == 400) begin
                fail_count++;
                end_sim;
            end
            if (k < 16) chk(rData, 8'hA0 + k[7:0]);
            if (k < 16) chk({4'h0, rIdx}, k[7:0]);
            step;
        end
        chk({6'h0, csN, busy}, 8'h02);
        chk(last, 8'hAF);
        start = 0;
    endtask
    task automatic t_bus;
        cyc(16'h00E0, 1, 1);
        chk({5'h0, csN, crdN, waitO}, 8'h01);
        repeat (11) step;
        chk({7'h0, waitO}, 8'h00);
        idle;
        useHi = 1;
        cyc(16'hE012, 1, 0);
        chk({6'h0, csN, cwrN}, 8'h00);
        idle;
        cyc(16'h12E0, 1, 1);
        chk({7'h0, csN}, 8'h01);
        idle;
        mode = `AHBG_DECODE_BIT;
        cyc(16'h00FE, 1, 1);
        chk({7'h0, csN}, 8'h00);
        idle;
        mode = `AHBG_DECODE_MEM;
        cyc(16'h4000, 0, 1);
        chk({5'h0, csN, memRd, memWr}, 8'h02);
        idle;
        cyc(16'h4000, 0, 0);
        chk({5'h0, csN, memRd, memWr}, 8'h01);
        idle;
        cyc(16'h4001, 0, 1);
        chk({7'h0, csN}, 8'h01);
        idle;
    endtask
    initial begin
        repeat (12) step;
        reset_n = 1;
        step;
        t_collect;
        t_bus;
        end_sim;
    end
endmodule // adc_host_bus_glue_test

// *** tb/ahbg_chk_asserts.sv ***
// Checker for the converter host glue
`timescale 1ns/1ps
`include "ahbg_map.vh"
module ahbg_chk (
    input logic        clk,
    input logic        reset_n,
    input logic        cpuRead_n,
    input logic        cpuWrite_n,
    input logic        memory_request_n,
    input logic        io_request_n,
    input logic        useHighByte,
    input logic        collectBusy,
    input logic        collectDone,
    input logic        cpuWait,
    input logic        conv_cs_n,
    input logic        conv_rd_n,
    input logic        conv_wr_n,
    input logic        mem_read_strobe,
    input logic        mem_write_strobe,
    input logic        resultValid,
    input logic [15:0] cpuAddr,
    input logic [1:0]  decodeMode
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    wire [7:0] ioA = useHighByte ? cpuAddr[15:8] : cpuAddr[7:0];
    wire       ioRd = !io_request_n && !cpuRead_n && memory_request_n && !collectBusy;
    wire       ioHit = ioRd && decodeMode == `AHBG_DECODE_IO && ioA == `AHBG_IO_PORT;
    a_io_sel: assert property (ioHit |-> !conv_cs_n && !conv_rd_n)
        else $error("port read not selected");
    a_io_other: assert property (ioRd && decodeMode == 2'h0 && !ioHit |-> conv_cs_n)
        else $error("select on foreign port");
    a_bit_sel: assert property (ioRd && decodeMode == 2'h1 && !cpuAddr[0] |-> !conv_cs_n)
        else $error("bit select missing");
    a_mem_rd: assert property (mem_read_strobe == (!cpuRead_n && !memory_request_n))
        else $error("memory read strobe wrong");
    a_mem_wr: assert property (mem_write_strobe == (!cpuWrite_n && !memory_request_n))
        else $error("memory write strobe wrong");
    a_io_wait: assert property (ioHit && $fell(cpuRead_n) |-> cpuWait)
        else $error("no wait on port cycle");
    a_done_cs: assert property (collectDone |-> conv_cs_n)
        else $error("select low when done");
    a_valid_one: assert property (resultValid |=> !resultValid)
        else $error("result pulse too long");
    a_wr_cs: assert property ($fell(conv_wr_n) |-> !conv_cs_n && conv_rd_n)
        else $error("start without select");
    a_busy_sel: assert property (collectBusy |-> !conv_cs_n)
        else $error("select high while collecting");
    a_clear_rd: assert property ($rose(collectBusy) |-> !conv_rd_n && conv_wr_n)
        else $error("no clearing read at start");
    a_wr_width: assert property (collectBusy && $fell(conv_wr_n) |-> !conv_wr_n [*8])
        else $error("start strobe too short");
endmodule // ahbg_chk
bind ahbg_host_glue ahbg_chk i_chk (
    .clk              (clk),
    .reset_n          (reset_n),
    .cpuRead_n        (cpuRead_n),
    .cpuWrite_n       (cpuWrite_n),
    .memory_request_n (memory_request_n),
    .io_request_n     (io_request_n),
    .useHighByte      (useHighByte),
    .collectBusy      (collectBusy),
    .collectDone      (collectDone),
    .cpuWait          (cpuWait),
    .conv_cs_n        (conv_cs_n),
    .conv_rd_n        (conv_rd_n),
    .conv_wr_n        (conv_wr_n),
    .mem_read_strobe  (mem_read_strobe),
    .mem_write_strobe (mem_write_strobe),
    .resultValid      (resultValid),
    .cpuAddr          (cpuAddr),
    .decodeMode       (decodeMode)
);

// *** tb/ahbg_conv_model.sv ***
// Behavioural converter on the far side of the glue
`timescale 1ns/1ps
module ahbg_conv_model #(parameter int CONV_CYC = 30) (
    input logic        clk,
    input logic        cs_n,
    input logic        rd_n,
    input logic        wr_n,
    output logic       intr_n,
    output logic [7:0] data
);
    logic [7:0] res = 8'h00;
    logic [7:0] nxt = 8'hA0;
    logic       wrQ = 1'b1;
    int         cnt = 0;
    initial intr_n = 1'b1;
    assign data = (!cs_n && !rd_n) ? res : ~res;
    always @(posedge clk) begin
        wrQ <= wr_n;
        if (!cs_n && !rd_n) intr_n <= 1'b1;
        if (!cs_n && wr_n && !wrQ) begin
            cnt <= CONV_CYC;
            intr_n <= 1'b1;
        end else if (cnt == 1) begin
            res <= nxt;
            nxt <= nxt + 8'h01;
            intr_n <= 1'b0;
            cnt <= 0;
        end else if (cnt > 1) cnt <= cnt - 1;
    end
endmodule // ahbg_conv_model
